//--- core/fwr_pkg.sv
// constants and types for the flash read, wrap and reset command block
package fwr_pkg;

   // timing
   localparam int unsigned CLK_NS    = 40;
   localparam int unsigned RCH_NS    = 40;
   localparam int unsigned RCH_RAW   = (RCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RCH_CYC   = (RCH_RAW < 1) ? 1 : RCH_RAW;

   // opcodes
   localparam logic [7:0]  OP_DUAL_IO_RD = 8'hbb;
   localparam logic [7:0]  OP_QUAD_IO_RD = 8'heb;
   localparam logic [7:0]  OP_SET_WRAP   = 8'h77;
   localparam logic [7:0]  OP_SET_PARAM  = 8'hc0;
   localparam logic [7:0]  OP_RST_EN     = 8'h66;
   localparam logic [7:0]  OP_RST        = 8'h99;

   // frame lengths in bits or clocks
   localparam int unsigned OPC_BITS      = 8;
   localparam int unsigned ADDR_BITS     = 24;
   localparam int unsigned MODE_BITS     = 8;
   localparam int unsigned WRAP_ARG_CLK  = 8;
   localparam int unsigned PARAM_ARG_CLK = 2;
   localparam int unsigned QSPI_DUMMY    = 4;
   localparam int unsigned QPI_MODE_CLK  = 4;
   localparam int unsigned DUMMY_MIN     = 4;
   localparam int unsigned DUMMY_MID     = 6;
   localparam int unsigned DUMMY_MAX     = 8;
   localparam int unsigned WRAP_MIN_BYTES = 8;

   // field positions
   localparam int unsigned MODE_CONT_HI  = 5;
   localparam int unsigned MODE_CONT_LO  = 4;
   localparam int unsigned WRAP_ARG_HI   = 6;
   localparam int unsigned WRAP_ARG_LO   = 4;
   localparam int unsigned PARAM_DUM_HI  = 5;
   localparam int unsigned PARAM_DUM_LO  = 4;
   localparam int unsigned PARAM_WLEN_HI = 1;
   localparam int unsigned PARAM_WLEN_LO = 0;
   localparam logic [1:0]  CONT_ON       = 2'h2;

   // reset values; wrap setting is {length[1:0], disable}
   localparam logic [2:0]  WRAP_SET_RST  = 3'h1;
   localparam logic [7:0]  PARAM_RST     = 8'h00;

   typedef enum logic [1:0] {
      LN_1 = 2'h0,
      LN_2 = 2'h1,
      LN_4 = 2'h2
   } fwr_lanes_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_OPC   = 3'h1,
      ST_ADDR  = 3'h3,
      ST_MODE  = 3'h2,
      ST_DUMMY = 3'h6,
      ST_DATA  = 3'h7,
      ST_ARG   = 3'h5,
      ST_SKIP  = 3'h4
   } fwr_state_t;

endpackage

//--- core/fwr_pin_if.sv
// synchronised link pins and their edges
`timescale 1ns/1ns
`default_nettype none
interface fwr_pin_if;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_fall;
   logic       cs_rise;
   logic       cs_low;
   logic [3:0] io;

   modport src (output sclk_rise, output sclk_fall, output cs_fall, output cs_rise,
                output cs_low, output io);
   modport dst (input sclk_rise, input sclk_fall, input cs_fall, input cs_rise,
                input cs_low, input io);
endinterface
`default_nettype wire

//--- core/fwr_pin_sync.sv
// two-stage synchroniser and edge finder for the serial link pins
`timescale 1ns/1ns
`default_nettype none
module fwr_pin_sync
   import fwr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // raw pins
   input  wire logic       sclk_i,
   input  wire logic       cs_n_i,
   input  wire logic [3:0] io_i,
   // synchronised side
   fwr_pin_if.src          pins
);

   logic       sclk_s1_q;
   logic       sclk_s2_q;
   logic       sclk_s3_q;
   logic       csn_s1_q;
   logic       csn_s2_q;
   logic       csn_s3_q;
   logic [3:0] io_s1_q;
   logic [3:0] io_s2_q;

   // io shares the sclk latency so a rise sees the data it latched
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         csn_s1_q  <= 1'b1;
         csn_s2_q  <= 1'b1;
         csn_s3_q  <= 1'b1;
         io_s1_q   <= 4'h0;
         io_s2_q   <= 4'h0;
      end
      else
      begin
         sclk_s1_q <= sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         csn_s1_q  <= cs_n_i;
         csn_s2_q  <= csn_s1_q;
         csn_s3_q  <= csn_s2_q;
         io_s1_q   <= io_i;
         io_s2_q   <= io_s1_q;
      end
   end

   assign pins.sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign pins.sclk_fall = ~sclk_s2_q & sclk_s3_q;
   assign pins.cs_fall   = ~csn_s2_q & csn_s3_q;
   assign pins.cs_rise   = csn_s2_q & ~csn_s3_q;
   assign pins.cs_low    = ~csn_s2_q;
   assign pins.io        = io_s2_q;

endmodule
`default_nettype wire

//--- core/fwr_cmd.sv
// command interpreter: dual/quad io reads, burst wrap, software reset
`timescale 1ns/1ns
`default_nettype none
module fwr_cmd
   import fwr_pkg::*;
#(
   parameter int unsigned CNT_W = 5
)
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // serial link
   input  wire logic                 sclk_i,
   input  wire logic                 cs_n_i,
   input  wire logic [3:0]           io_i,
   output logic      [3:0]           io_o,
   output logic      [3:0]           io_oe_o,
   // configuration
   input  wire logic                 quad_enable_bit_i,
   input  wire logic                 quad_command_mode_i,
   input  wire logic                 deep_powerdown_i,
   // array read port
   output logic      [ADDR_BITS-1:0] arr_addr_o,
   output logic                      arr_rd_o,
   input  wire logic [7:0]           arr_data_i,
   // status
   output logic      [2:0]           wrap_setting_o,
   output logic      [7:0]           read_parameter_o,
   output logic                      continuous_mode_o,
   output logic                      soft_reset_o
);

   if (CNT_W < 5 || CNT_W > 8 || RCH_CYC > 255)
   begin : g_chk
      $error("fwr_cmd: counter width must be 5 to 8");
   end

   fwr_pin_if pins ();

   fwr_pin_sync u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sclk_i (sclk_i),
      .cs_n_i (cs_n_i),
      .io_i   (io_i),
      .pins   (pins)
   );

   fwr_state_t             state_q;
   fwr_lanes_t             lanes_q;
   logic [CNT_W-1:0]       cnt_q;
   logic [CNT_W-1:0]       last_q;
   logic [ADDR_BITS-1:0]   sh_q;
   logic                   quad_rd_q;
   logic                   arg_wrap_q;
   logic                   cont_q;
   logic                   cont_quad_q;
   logic                   rst_en_q;
   logic                   armed_q;
   logic [7:0]             hold_q;
   logic [2:0]             wrap_q;
   logic [7:0]             param_q;
   logic                   srst_q;
   logic [ADDR_BITS-1:0]   addr_q;
   logic [7:0]             nxt_q;
   logic [7:0]             ob_q;
   logic [1:0]             ocnt_q;
   logic [3:0]             io_q;
   logic [3:0]             oe_q;
   logic                   rd_q;
   logic                   rd_p_q;

   logic [ADDR_BITS-1:0]   sh_nxt;
   logic                   phase_end;
   logic                   opc_end;
   logic [7:0]             opc;
   logic [CNT_W-1:0]       extra;
   logic                   enter_data;
   logic                   wrap_on;
   logic                   byte_step;
   logic [7:0]             cur_byte;

   function automatic logic [ADDR_BITS-1:0] shift_in(input logic [ADDR_BITS-1:0] s,
                                                      input logic [3:0]           d,
                                                      input fwr_lanes_t           ln);
      unique case (ln)
         LN_4:    return {s[ADDR_BITS-5:0], d};
         LN_2:    return {s[ADDR_BITS-3:0], d[1:0]};
         default: return {s[ADDR_BITS-2:0], d[0]};
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] clocks_for(input int unsigned bits,
                                                   input fwr_lanes_t  ln);
      unique case (ln)
         LN_4:    return CNT_W'(bits / 4);
         LN_2:    return CNT_W'(bits / 2);
         default: return CNT_W'(bits);
      endcase
   endfunction

   // clocks between the mode byte and data
   function automatic logic [CNT_W-1:0] read_dummy(input logic [7:0] p,
                                                   input logic       quad_command_mode,
                                                   input logic       quad);
      int unsigned total;
      total = DUMMY_MIN;
      if (!quad)
         return '0;
      if (!quad_command_mode)
         return CNT_W'(QSPI_DUMMY);
      unique case (p[PARAM_DUM_HI:PARAM_DUM_LO])
         2'h1:       total = DUMMY_MID;
         2'h2, 2'h3: total = DUMMY_MAX;
         default:    total = DUMMY_MIN;
      endcase
      return CNT_W'(total - QPI_MODE_CLK);
   endfunction

   // byte mask of the aligned wrap section
   function automatic logic [ADDR_BITS-1:0] section_mask(input logic [1:0] len);
      return ADDR_BITS'((WRAP_MIN_BYTES << len) - 1);
   endfunction

   function automatic logic [ADDR_BITS-1:0] next_addr(input logic [ADDR_BITS-1:0] a,
                                                       input logic                 on,
                                                       input logic [1:0]           len);
      logic [ADDR_BITS-1:0] mask;
      logic [ADDR_BITS-1:0] inc;
      mask = section_mask(len);
      inc  = a + 1'b1;
      return on ? ((a & ~mask) | (inc & mask)) : inc;
   endfunction

   assign sh_nxt     = shift_in(sh_q, pins.io, lanes_q);
   assign phase_end  = pins.sclk_rise && pins.cs_low && (cnt_q == last_q);
   assign opc_end    = phase_end && (state_q == ST_OPC);
   assign opc        = sh_nxt[7:0];
   assign extra      = read_dummy(param_q, quad_command_mode_i, quad_rd_q);
   assign enter_data = phase_end && ((state_q == ST_DUMMY) ||
                                     ((state_q == ST_MODE) && (extra == '0)));
   // wrap only for quad io read outside quad command mode
   assign wrap_on    = !wrap_q[0] && quad_rd_q && !quad_command_mode_i;
   assign byte_step  = (state_q == ST_DATA) && pins.sclk_fall && pins.cs_low &&
                       (ocnt_q == 2'h0);
   assign cur_byte   = (ocnt_q == 2'h0) ? nxt_q : ob_q;

   // frame sequencing on sampled rising edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !pins.cs_low)
      begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         last_q     <= '0;
         lanes_q    <= LN_1;
         sh_q       <= '0;
         arg_wrap_q <= 1'b0;
         if (rst_i)
            quad_rd_q <= 1'b0;
      end
      else if (pins.cs_fall)
      begin
         cnt_q <= '0;
         if (cont_q)
         begin
            // no opcode expected in continuous read
            state_q   <= ST_ADDR;
            lanes_q   <= cont_quad_q ? LN_4 : LN_2;
            last_q    <= clocks_for(ADDR_BITS, cont_quad_q ? LN_4 : LN_2) - 1'b1;
            quad_rd_q <= cont_quad_q;
         end
         else
         begin
            state_q <= ST_OPC;
            lanes_q <= quad_command_mode_i ? LN_4 : LN_1;
            last_q  <= clocks_for(OPC_BITS, quad_command_mode_i ? LN_4 : LN_1) - 1'b1;
         end
      end
      else if (pins.sclk_rise)
      begin
         sh_q  <= sh_nxt;
         cnt_q <= (cnt_q == last_q) ? '0 : cnt_q + 1'b1;
         if (cnt_q == last_q)
         begin
            unique case (state_q)
               ST_OPC:
               begin
                  state_q <= ST_SKIP;
                  if (opc == OP_DUAL_IO_RD && !quad_command_mode_i)
                  begin
                     state_q   <= ST_ADDR;
                     lanes_q   <= LN_2;
                     last_q    <= clocks_for(ADDR_BITS, LN_2) - 1'b1;
                     quad_rd_q <= 1'b0;
                  end
                  else if (opc == OP_QUAD_IO_RD && quad_enable_bit_i)
                  begin
                     state_q   <= ST_ADDR;
                     lanes_q   <= LN_4;
                     last_q    <= clocks_for(ADDR_BITS, LN_4) - 1'b1;
                     quad_rd_q <= 1'b1;
                  end
                  else if (opc == OP_SET_WRAP && quad_enable_bit_i && !quad_command_mode_i)
                  begin
                     state_q    <= ST_ARG;
                     lanes_q    <= LN_4;
                     last_q     <= CNT_W'(WRAP_ARG_CLK - 1);
                     arg_wrap_q <= 1'b1;
                  end
                  else if (opc == OP_SET_PARAM && quad_command_mode_i)
                  begin
                     state_q    <= ST_ARG;
                     lanes_q    <= LN_4;
                     last_q     <= CNT_W'(PARAM_ARG_CLK - 1);
                     arg_wrap_q <= 1'b0;
                  end
               end
               ST_ADDR:
               begin
                  state_q <= ST_MODE;
                  last_q  <= clocks_for(MODE_BITS, lanes_q) - 1'b1;
               end
               ST_MODE:
               begin
                  state_q <= (extra == '0) ? ST_DATA : ST_DUMMY;
                  last_q  <= extra - 1'b1;
               end
               ST_DUMMY: state_q <= ST_DATA;
               ST_ARG:   state_q <= ST_SKIP;
               ST_IDLE, ST_DATA, ST_SKIP:
               begin
                  state_q <= state_q;
               end
            endcase
         end
      end
   end

   // continuous read bits; low mode nibble never looked at
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cont_q      <= 1'b0;
         cont_quad_q <= 1'b0;
      end
      else if (phase_end && state_q == ST_MODE)
      begin
         cont_q      <= (sh_nxt[MODE_CONT_HI:MODE_CONT_LO] == CONT_ON);
         cont_quad_q <= quad_rd_q;
      end
   end

   // clocks since the last link rising edge, for the reset hold check
   always_ff @(posedge clk_i)
   begin
      if (rst_i || pins.sclk_rise)
         hold_q <= 8'h00;
      else if (hold_q != 8'hff)
         hold_q <= hold_q + 8'h01;
   end

   // volatile settings and the software reset sequence
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wrap_q   <= WRAP_SET_RST;
         param_q  <= PARAM_RST;
         rst_en_q <= 1'b0;
         armed_q  <= 1'b0;
         srst_q   <= 1'b0;
      end
      else
      begin
         srst_q <= 1'b0;
         if (pins.cs_rise && armed_q && hold_q >= 8'(RCH_CYC))
         begin
            // continuous read state deliberately kept
            wrap_q   <= WRAP_SET_RST;
            param_q  <= PARAM_RST;
            rst_en_q <= 1'b0;
            armed_q  <= 1'b0;
            srst_q   <= 1'b1;
         end
         else if (opc_end)
         begin
            rst_en_q <= (opc == OP_RST_EN);
            armed_q  <= (opc == OP_RST) && rst_en_q && !deep_powerdown_i &&
                        !cont_q;
         end
         else if (pins.sclk_rise)
         begin
            // extra clocks after the reset opcode void it
            armed_q <= 1'b0;
            if (phase_end && state_q == ST_ARG)
            begin
               if (arg_wrap_q)
                  wrap_q <= sh_nxt[WRAP_ARG_HI:WRAP_ARG_LO];
               else
               begin
                  param_q   <= sh_nxt[7:0];
                  wrap_q[2:1] <= sh_nxt[PARAM_WLEN_HI:PARAM_WLEN_LO];
               end
            end
         end
      end
   end

   // data path: array fetch and output on falling edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         addr_q <= '0;
         nxt_q  <= 8'h00;
         ob_q   <= 8'h00;
         ocnt_q <= 2'h0;
         io_q   <= 4'h0;
         oe_q   <= 4'h0;
         rd_q   <= 1'b0;
         rd_p_q <= 1'b0;
      end
      else
      begin
         rd_q   <= 1'b0;
         rd_p_q <= rd_q;
         if (rd_p_q)
            nxt_q <= arr_data_i;
         if (!pins.cs_low)
         begin
            oe_q   <= 4'h0;
            ocnt_q <= 2'h0;
         end
         if (phase_end && state_q == ST_ADDR)
            addr_q <= sh_nxt;
         if (enter_data)
         begin
            rd_q   <= 1'b1;
            ocnt_q <= 2'h0;
         end
         // lines driven on every data fall, turned round from the first one on
         if ((state_q == ST_DATA) && pins.sclk_fall && pins.cs_low)
         begin
            if (lanes_q == LN_4)
            begin
               io_q   <= cur_byte[7:4];
               oe_q   <= 4'hf;
               ob_q   <= {cur_byte[3:0], 4'h0};
               ocnt_q <= (ocnt_q == 2'h1) ? 2'h0 : 2'h1;
            end
            else
            begin
               io_q   <= {2'h0, cur_byte[7:6]};
               oe_q   <= 4'h3;
               ob_q   <= {cur_byte[5:0], 2'h0};
               ocnt_q <= ocnt_q + 2'h1;
            end
            if (ocnt_q == 2'h0)
            begin
               addr_q <= next_addr(addr_q, wrap_on, wrap_q[2:1]);
               rd_q   <= 1'b1;
            end
         end
      end
   end

   assign io_o              = io_q;
   assign io_oe_o           = oe_q;
   assign arr_addr_o        = addr_q;
   assign arr_rd_o          = rd_q;
   assign wrap_setting_o    = wrap_q;
   assign read_parameter_o  = param_q;
   assign continuous_mode_o = cont_q;
   assign soft_reset_o      = srst_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_addr_done;
      (state_q == ST_ADDR) && phase_end;
   endsequence

   sequence s_quad_refused;
      opc_end && (opc == OP_QUAD_IO_RD) && !quad_enable_bit_i;
   endsequence

   property p_wrap_in_section;
      byte_step && wrap_on |=>
         ((addr_q & ~section_mask(wrap_q[2:1])) ==
          ($past(addr_q) & ~section_mask(wrap_q[2:1])));
   endproperty

   AST_ADDR_TO_MODE: assert property (s_addr_done |=> (state_q == ST_MODE) &&
                                      (addr_q == $past(sh_nxt)))
      else $error("address phase did not hand over to mode byte");
   AST_QE_GATES_QUAD: assert property (s_quad_refused |=> state_q == ST_SKIP)
      else $error("quad read taken without quad enable");
   AST_CONT_SKIPS_OPC: assert property (pins.cs_fall && pins.cs_low && cont_q
                                        |=> state_q == ST_ADDR)
      else $error("continuous read did not start at the address");
   AST_NORMAL_OPC: assert property (pins.cs_fall && pins.cs_low && !cont_q
                                    |=> state_q == ST_OPC)
      else $error("frame did not start with an opcode");
   AST_SRST_KEEPS_CONT: assert property (srst_q |-> cont_q == $past(cont_q, 2))
      else $error("software reset changed continuous read state");
   AST_SRST_DEFAULTS: assert property ($rose(srst_q) |-> $past(armed_q) &&
                                       wrap_q == WRAP_SET_RST && param_q == PARAM_RST)
      else $error("software reset without enable or defaults not restored");
   AST_CANCEL_EN: assert property (opc_end && opc != OP_RST_EN |=> !rst_en_q)
      else $error("reset enable survived another opcode");
   AST_NO_RST_IN_PD: assert property (opc_end && deep_powerdown_i |=> !armed_q)
      else $error("reset armed in deep power-down");
   AST_NO_RST_IN_CONT: assert property (pins.cs_rise && cont_q |=> !srst_q)
      else $error("software reset taken during continuous read");
   AST_WRAP_SECTION: assert property (p_wrap_in_section)
      else $error("wrapped read left its section");
   AST_DATA_DRIVEN: assert property (enter_data ##1 (state_q == ST_DATA) [*1]
                                     ##[1:12] (pins.sclk_fall && pins.cs_low) |=> oe_q != 4'h0)
      else $error("data not driven on first falling edge");

endmodule
`default_nettype wire

//--- verification/fwr_host_model.sv
// host flash controller model for the serial link
`timescale 1ns/1ns
`default_nettype none
module fwr_host_model
(
   // clock
   input  wire logic       clk_i,
   // link
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic [3:0]      io_o
);
   logic [31:0] s;
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      io_o   = 4'h0;
   end
   // four clocks a half period: 160 ns high or low, a 320 ns link period
   task automatic half();
      repeat (4) @(posedge clk_i);
   endtask
   task automatic tick();
      half();
      sclk_o <= 1'b1;
      half();
      sclk_o <= 1'b0;
   endtask
   // msb first, n clocks of w lanes
   task automatic send(input int n, input int w, input logic [31:0] d);
      s = d << (32 - n * w);
      for (int i = 0; i < n; i++)
      begin
         io_o <= (w == 4) ? s[31:28] :
                 (w == 2) ? {2'h0, s[31:30]} : {3'h0, s[31]};
         s = s << w;
         tick();
      end
   endtask
   // released lines have no pull, so they wander
   task automatic idle(input int n);
      for (int i = 0; i < n; i++)
      begin
         io_o <= ~io_o;
         tick();
      end
   endtask
   task automatic frame_on();
      half();
      cs_n_o <= 1'b0;
   endtask
   // hold after the last fall before chip select rises
   task automatic frame_off();
      half();
      cs_n_o <= 1'b1;
      half();
      half();
   endtask
endmodule
`default_nettype wire

//--- verification/fwr_cmd_tb.sv
// self-checking bench for the read, wrap and reset command block
`timescale 1ns/1ns
`default_nettype none
module fwr_cmd_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, qe = 1'b0, quad_command_mode = 1'b0, dpd = 1'b0, arr_rd, srst;
   logic [3:0] h_io, d_io, d_oe, io_w;
   logic sclk, cs_n, cont;
   logic [7:0] arr_data = 8'h00, param;
   logic [23:0] arr_addr;
   logic [2:0] wrap;
   logic [23:0] rq[$];
   int errors = 0, compares = 0, nrst = 0, cyc = 0;
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin errors++; \
   $display("ERROR %s expected %h seen %h", n, e, v); end end
   always #20 clk_i = ~clk_i;
   assign io_w = (d_oe & d_io) | (~d_oe & h_io);
   fwr_host_model u_h (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io));
   fwr_cmd u_dut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w),
      .io_o(d_io), .io_oe_o(d_oe), .quad_enable_bit_i(qe), .quad_command_mode_i(quad_command_mode),
      .deep_powerdown_i(dpd), .arr_addr_o(arr_addr), .arr_rd_o(arr_rd),
      .arr_data_i(arr_data), .wrap_setting_o(wrap), .read_parameter_o(param),
      .continuous_mode_o(cont), .soft_reset_o(srst));
   // array stand-in and fetch log
   always @(posedge clk_i)
   begin
      cyc++;
      if (srst === 1'b1)
         nrst++;
      if (arr_rd === 1'b1)
      begin
         arr_data <= arr_addr[7:0];
         if (rq.size() == 0 || rq[$] !== arr_addr)
            rq.push_back(arr_addr);
      end
      if (cyc == 20000)
      begin
         errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic op(input logic [7:0] b);
      u_h.frame_on();
      u_h.send(8, 1, {24'h0, b});
      u_h.frame_off();
   endtask
   task automatic set_wrap(input logic [7:0] w);
      u_h.frame_on();
      u_h.send(8, 1, 32'h77);
      u_h.send(8, 4, {24'h0, w});
      u_h.frame_off();
   endtask
   // quad read body: address, mode, dummy plus data clocks
   task automatic qread(input logic [23:0] a, input logic [7:0] m, input int n);
      u_h.send(6, 4, {8'h0, a});
      u_h.send(2, 4, {24'h0, m});
      u_h.idle(n);
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("wrap_rst", 3'h1, wrap)
      `CHK("param_rst", 8'h00, param)
      set_wrap(8'h00);
      `CHK("wrap_no_qe", 3'h1, wrap)
      op(8'heb);
      `CHK("quad_no_qe", 0, rq.size())
      qe <= 1'b1;
      set_wrap(8'h60);
      `CHK("wrap_64", 3'h6, wrap)
      set_wrap(8'h00);
      `CHK("wrap_8", 3'h0, wrap)
      rq.delete();
      u_h.frame_on();
      u_h.send(8, 1, 32'heb);
      qread(24'h000006, 8'ha5, 12);
      `CHK("quad_oe", 4'hf, d_oe)
      `CHK("quad_data", 4'h1, d_io)
      u_h.frame_off();
      `CHK("oe_off", 4'h0, d_oe)
      for (int i = 0; i < 4; i++)
         `CHK("wrap_addr", (24'h6 + i) & 24'h7, rq[i])
      `CHK("cont_on", 1'b1, cont)
      rq.delete();
      u_h.frame_on();
      qread(24'h000010, 8'ha5, 6);
      u_h.frame_off();
      `CHK("cont_addr", 24'h10, rq[0])
      `CHK("cont_again", 1'b1, cont)
      // in continuous read the enable frame is taken as address and mode
      op(8'h66);
      op(8'h99);
      `CHK("rst_in_cont", 0, nrst)
      `CHK("cont_off", 1'b0, cont)
      op(8'h66);
      op(8'h05);
      op(8'h99);
      `CHK("rst_cancel", 0, nrst)
      dpd <= 1'b1;
      op(8'h66);
      op(8'h99);
      `CHK("rst_dpd", 0, nrst)
      dpd <= 1'b0;
      rq.delete();
      u_h.frame_on();
      u_h.send(8, 1, 32'hbb);
      u_h.send(12, 2, {8'h0, 24'h00002d});
      u_h.send(4, 2, 32'h0);
      u_h.idle(7);
      `CHK("dual_oe", 4'h3, d_oe)
      `CHK("dual_data", 4'h3, d_io)
      u_h.frame_off();
      `CHK("dual_addr", 24'h2d, rq[0])
      `CHK("dual_next", 24'h2e, rq[1])
      quad_command_mode <= 1'b1;
      u_h.frame_on();
      u_h.send(4, 4, 32'hc021);
      u_h.frame_off();
      `CHK("param_set", 8'h21, param)
      `CHK("qpi_wlen", 3'h2, wrap)
      rq.delete();
      u_h.frame_on();
      u_h.send(2, 4, 32'heb);
      qread(24'h00000e, 8'h00, 12);
      `CHK("qpi_dummy", 4'h1, d_io)
      u_h.frame_off();
      `CHK("qpi_no_wrap", 24'h10, rq[2])
      quad_command_mode <= 1'b0;
      op(8'h66);
      op(8'h99);
      `CHK("rst_done", 1, nrst)
      `CHK("param_clr", 8'h00, param)
      `CHK("wrap_clr", 3'h1, wrap)
      `CHK("cont_kept", 1'b0, cont)
      // wrap setting was lost with the reset, so it is sent again
      set_wrap(8'h60);
      `CHK("wrap_again", 3'h6, wrap)
      conclude();
   end
endmodule
`default_nettype wire
